// >>> core/mmd_consts.svh
// mmd_consts.svh: offsets, field positions and limits of the transfer engine
// assumes: included by bare name from every design file that needs it
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH
// register word offsets on the plain register port (address is a word index)
`define MMD_REG_SAR      8'h00
`define MMD_REG_DAR      8'h01
`define MMD_REG_CNT      8'h02
`define MMD_REG_RPT      8'h03
`define MMD_REG_MODE     8'h04
`define MMD_REG_OFS      8'h05
`define MMD_REG_CTRL     8'h06
`define MMD_REG_STAT     8'h07
`define MMD_REG_MASK     8'h08
`define MMD_REG_ISTAT    8'h09
`define MMD_REG_EXTCFG   8'h0A
// channel stride: registers of channel n live at n*stride + offset
`define MMD_CH_STRIDE    8'h10
// mode register fields
`define MMD_MODE_SZ_LO   0
`define MMD_MODE_TM_LO   2
`define MMD_MODE_SM_LO   4
`define MMD_MODE_DM_LO   6
`define MMD_MODE_SEL_LO  8
`define MMD_MODE_EXT_LO  12
`define MMD_MODE_RIE     16
`define MMD_MODE_EIE     17
// control register fields
`define MMD_CTRL_EN      0
`define MMD_CTRL_SWT     1
// status bits of the interrupt status register
`define MMD_IRQ_END      0
`define MMD_IRQ_ESC      1
// address windows
`define MMD_LOW_TOP      32'h0FFF_FFFF
`define MMD_HIGH_BASE    32'hF000_0000
// limits
`define MMD_BLK_MAX      11'h400
`endif

// >>> core/mmd_pkg.sv
// mmd_pkg: types shared by the transfer engine files
// assumes: the constants header is included beside it
package mmd_pkg;
  typedef enum logic [1:0] {
    MMD_SZ_8,
    MMD_SZ_16,
    MMD_SZ_32,
    MMD_SZ_RSV
  } mmd_size_t;
  typedef enum logic [1:0] {
    MMD_TM_NORMAL,
    MMD_TM_REPEAT,
    MMD_TM_BLOCK,
    MMD_TM_RSV
  } mmd_tmode_t;
  typedef enum logic [1:0] {
    MMD_AM_FIXED,
    MMD_AM_OFFSET,
    MMD_AM_INC,
    MMD_AM_DEC
  } mmd_amode_t;
  typedef enum logic [1:0] {
    MMD_EX_LOW,
    MMD_EX_FALL,
    MMD_EX_RISE,
    MMD_EX_BOTH
  } mmd_edge_t;
endpackage

// >>> core/mmd_ext_trig.sv
// mmd_ext_trig: synchronises external trigger pins and detects their events
// assumes: pins are asynchronous to mclk; one request pulse per edge event, a request every cycle while a low-level pin is low
`timescale 1ns/100ps
`default_nettype none
module mmd_ext_trig
  import mmd_pkg::*;
#(
  parameter int N = 16
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic [N-1:0]    pin,
  input  wire logic [2*N-1:0]  cfg,
  output logic      [N-1:0]    req
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] rq;
  } mmd_xt_t;
  mmd_xt_t st;
  mmd_xt_t next_st;
  mmd_edge_t ed [N];

  // ---------------------------------------------------------------
  // event detect
  // ---------------------------------------------------------------
  // s1 is read only by s2; edges are taken between s2 and s3
  always_comb begin
    next_st    = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < N; i++) begin
      ed[i] = mmd_edge_t'(cfg[2*i +: 2]);
      case (ed[i])
        MMD_EX_LOW:  next_st.rq[i] = ~st.s2[i];
        MMD_EX_FALL: next_st.rq[i] = st.s3[i] & ~st.s2[i];
        MMD_EX_RISE: next_st.rq[i] = ~st.s3[i] & st.s2[i];
        default:     next_st.rq[i] = st.s3[i] ^ st.s2[i];
      endcase
    end
  end

  // state register; idle pins assumed high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '{s1: '1, s2: '1, s3: '1, rq: '0};
    end else begin
      st <= next_st;
    end
  end

  assign req = st.rq;
endmodule
`default_nettype wire

// >>> core/mmd_arb.sv
// mmd_arb: fixed priority pick among pending channel requests
// assumes: lowest index wins; grant is combinational
`timescale 1ns/100ps
`default_nettype none
module mmd_arb #(
  parameter int NCH = 4
) (
  input  wire logic [NCH-1:0]          pend,
  output logic                         any,
  output logic [$clog2(NCH)-1:0]       idx
);
  // scan downward so the lowest pending index is left standing
  always_comb begin
    any = |pend;
    idx = '0;
    for (int i = NCH-1; i >= 0; i--) begin
      if (pend[i]) begin
        idx = ($clog2(NCH))'(i);
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/mmd_dma.sv
// mmd_dma: multi-channel transfer engine with normal, repeat and block modes
// assumes: single-cycle memory bus (read data in the bus_rd cycle, writes always taken)
//
// Notes on behaviour
// - generated addresses stay in the low or high 256 MB window only.
// - each unit is 8, 16 or 32 bits; every access uses that width.
// - source and destination each: fixed, offset, increment or decrement by unit.
// - offset update only on channel 0; elsewhere it acts as fixed.
// - normal mode: end interrupt when programmed transfer count completes.
// - repeat mode: end interrupt after programmed number of repetitions.
// - block mode: end interrupt after programmed number of blocks.
// - escape interrupt each time one repeat size of data has moved.
// - escape interrupt also when address leaves the extended repeat area.
// - block holds up to 1,024 units; up to 65,536 blocks.
// - trigger pins selectable low level, falling, rising or both edges.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "mmd_consts.svh"
module mmd_dma
  import mmd_pkg::*;
#(
  parameter int NCH  = 4,
  parameter int NSRC = 16,
  parameter int NEXT = 16
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // request sources
  input  wire logic [NSRC-1:0]      periph_req,
  input  wire logic [NEXT-1:0]      ext_pin,
  // memory bus
  output logic      [31:0]          bus_addr,
  output logic      [31:0]          bus_wdata,
  output logic      [3:0]           bus_be,
  output logic                      bus_rd,
  output logic                      bus_wr,
  input  wire logic [31:0]          bus_rdata,
  output logic                      irq
);
  localparam int CW = $clog2(NCH);

  typedef struct packed {
    logic [31:0] sar;
    logic [31:0] dar;
    logic [31:0] cnt;    // transfers (normal), repetitions, or blocks
    logic [10:0] rpt;    // repeat / block size in units
    logic [10:0] rleft;  // units left in current repeat area or block
    logic [31:0] sar0;   // start of repeat area, source
    logic [31:0] dar0;
    logic [17:0] mode;
    logic [31:0] ofs;
    logic        en;
    logic        pend;
    logic [1:0]  ist;
    logic [1:0]  imsk;
  } mmd_ch_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } mmd_fsm_t;

  typedef struct packed {
    mmd_ch_t [NCH-1:0] ch;
    mmd_fsm_t          fsm;
    logic [CW-1:0]     cur;
    logic [31:0]       data;
    logic [31:0]       rdata;
    logic [31:0]       baddr;
    logic [31:0]       bwdata;
    logic [3:0]        bbe;
    logic              brd;
    logic              bwr;
    logic [2*NEXT-1:0] extcfg;
    logic [NSRC-1:0]   preq_d;
  } mmd_st_t;

  mmd_st_t st;
  mmd_st_t next_st;

  logic [NEXT-1:0]     ext_req;
  logic [NCH-1:0]      pend_v;
  logic                arb_any;
  logic [CW-1:0]       arb_idx;
  logic [NSRC-1:0]     preq_s1;
  logic [NSRC-1:0]     preq_s2;

  mmd_ext_trig #(.N(NEXT)) u_ext (
    .mclk (mclk),
    .rst  (rst),
    .pin  (ext_pin),
    .cfg  (st.extcfg),
    .req  (ext_req)
  );

  mmd_arb #(.NCH(NCH)) u_arb (
    .pend (pend_v),
    .any  (arb_any),
    .idx  (arb_idx)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // fold a gap address into the window in the step direction (up: high base, down: low top unit); inside a window keep it
  function automatic logic [31:0] clamp_win(logic [31:0] a, logic up, logic [2:0] sz);
    logic [31:0] r;
    r = a;
    if (a > `MMD_LOW_TOP && a < `MMD_HIGH_BASE) begin
      r = up ? `MMD_HIGH_BASE : `MMD_LOW_TOP - {29'h0, sz} + 32'h1;
    end
    return r;
  endfunction

  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] am,
                                       input logic [2:0] sz, input logic [31:0] ofs,
                                       input logic ofs_ok);
    logic [31:0] r;
    r = a;
    case (mmd_amode_t'(am))
      MMD_AM_INC:    r = clamp_win(a + {29'h0, sz}, 1'b1, sz);
      MMD_AM_DEC:    r = clamp_win(a - {29'h0, sz}, 1'b0, sz);
      MMD_AM_OFFSET: r = ofs_ok ? clamp_win(a + ofs, 1'b1, sz) : a;
      default:       r = a;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] lo);
    logic [3:0] r;
    case (mmd_size_t'(sz))
      MMD_SZ_8:  r = 4'h1 << lo;
      MMD_SZ_16: r = lo[1] ? 4'hC : 4'h3;
      default:   r = 4'hF;
    endcase
    return r;
  endfunction

  // pending vector for the arbiter
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pend_v[i] = st.ch[i].pend & st.ch[i].en;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [2:0]  usz;
    logic [3:0]  sel;
    logic        hit;
    logic [7:0]  off;
    logic [CW-1:0] ci;
    logic [31:0] nsa;
    logic [31:0] nda;
    logic [31:0] ext_mask;
    logic        last_unit;
    logic        cnt_done;
    usz = 3'h1;
    sel = '0;
    hit = 1'b0;
    off = '0;
    ci  = '0;
    nsa = '0;
    nda = '0;
    ext_mask  = '0;
    last_unit = 1'b0;
    cnt_done  = 1'b0;
    next_st = st;
    next_st.brd = 1'b0;
    next_st.bwr = 1'b0;
    next_st.rdata = '0;
    next_st.preq_d = preq_s2;

    // request capture: peripheral rising edge, external event, software
    for (int i = 0; i < NCH; i++) begin
      sel = st.ch[i].mode[`MMD_MODE_SEL_LO +: 4];
      hit = (st.ch[i].mode[`MMD_MODE_EXT_LO] ? ext_req[sel]
                                             : (preq_s2[sel] & ~st.preq_d[sel]));
      if (hit) begin
        next_st.ch[i].pend = 1'b1;
      end
    end

    // register writes; software trigger sets pending like a hardware request
    if (reg_wr) begin
      ci  = reg_addr[CW+3:4];
      off = {4'h0, reg_addr[3:0]};
      if (reg_addr[7:4] >= 4'(NCH)) begin
        if (reg_addr[3:0] == `MMD_REG_EXTCFG) begin
          next_st.extcfg = reg_wdata[2*NEXT-1:0];
        end
      end else if (off == `MMD_REG_SAR) begin
        next_st.ch[ci].sar  = reg_wdata;
        next_st.ch[ci].sar0 = reg_wdata;
      end else if (off == `MMD_REG_DAR) begin
        next_st.ch[ci].dar  = reg_wdata;
        next_st.ch[ci].dar0 = reg_wdata;
      end else if (off == `MMD_REG_CNT) begin
        next_st.ch[ci].cnt = reg_wdata;
      end else if (off == `MMD_REG_RPT) begin
        next_st.ch[ci].rpt   = (reg_wdata[10:0] > `MMD_BLK_MAX) ? `MMD_BLK_MAX
                                                                  : reg_wdata[10:0];
        next_st.ch[ci].rleft = next_st.ch[ci].rpt;
      end else if (off == `MMD_REG_MODE) begin
        next_st.ch[ci].mode = reg_wdata[17:0];
      end else if (off == `MMD_REG_OFS) begin
        next_st.ch[ci].ofs = reg_wdata;
      end else if (off == `MMD_REG_CTRL) begin
        next_st.ch[ci].en = reg_wdata[`MMD_CTRL_EN];
        if (reg_wdata[`MMD_CTRL_SWT]) begin
          next_st.ch[ci].pend = 1'b1;
        end
      end else if (off == `MMD_REG_MASK) begin
        next_st.ch[ci].imsk = reg_wdata[1:0];
      end else if (off == `MMD_REG_ISTAT) begin
        next_st.ch[ci].ist = st.ch[ci].ist & ~reg_wdata[1:0];
      end
    end

    // register reads, answered the cycle after the strobe
    if (reg_rd) begin
      ci  = reg_addr[CW+3:4];
      off = {4'h0, reg_addr[3:0]};
      if (reg_addr[7:4] >= 4'(NCH)) begin
        next_st.rdata = (reg_addr[3:0] == `MMD_REG_EXTCFG) ? 32'(st.extcfg) : '0;
      end else if (off == `MMD_REG_SAR) begin
        next_st.rdata = st.ch[ci].sar;
      end else if (off == `MMD_REG_DAR) begin
        next_st.rdata = st.ch[ci].dar;
      end else if (off == `MMD_REG_CNT) begin
        next_st.rdata = st.ch[ci].cnt;
      end else if (off == `MMD_REG_RPT) begin
        next_st.rdata = {21'h0, st.ch[ci].rpt};
      end else if (off == `MMD_REG_MODE) begin
        next_st.rdata = {14'h0, st.ch[ci].mode};
      end else if (off == `MMD_REG_OFS) begin
        next_st.rdata = st.ch[ci].ofs;
      end else if (off == `MMD_REG_CTRL) begin
        next_st.rdata = {30'h0, st.ch[ci].pend, st.ch[ci].en};
      end else if (off == `MMD_REG_STAT) begin
        next_st.rdata = {21'h0, st.ch[ci].rleft};
      end else if (off == `MMD_REG_MASK) begin
        next_st.rdata = {30'h0, st.ch[ci].imsk};
      end else if (off == `MMD_REG_ISTAT) begin
        next_st.rdata = {30'h0, st.ch[ci].ist};
      end
    end

    // transfer engine: one unit per grant, read then write
    usz = (st.ch[st.cur].mode[1:0] == 2'(MMD_SZ_8))  ? 3'h1 :
          (st.ch[st.cur].mode[1:0] == 2'(MMD_SZ_16)) ? 3'h2 : 3'h4;
    case (st.fsm)
      ST_IDLE: begin
        if (arb_any) begin
          next_st.cur   = arb_idx;
          next_st.fsm   = ST_READ;
          next_st.brd   = 1'b1;
          next_st.baddr = st.ch[arb_idx].sar;
          next_st.bbe   = lanes(st.ch[arb_idx].mode[1:0], st.ch[arb_idx].sar[1:0]);
        end
      end
      ST_READ: begin
        next_st.data   = bus_rdata;
        next_st.fsm    = ST_WRITE;
        next_st.bwr    = 1'b1;
        next_st.baddr  = st.ch[st.cur].dar;
        next_st.bwdata = bus_rdata;
        next_st.bbe    = lanes(st.ch[st.cur].mode[1:0], st.ch[st.cur].dar[1:0]);
      end
      default: begin
        next_st.fsm = ST_IDLE;
        nsa = step(st.ch[st.cur].sar, st.ch[st.cur].mode[5:4], usz,
                   st.ch[st.cur].ofs, st.cur == '0);
        nda = step(st.ch[st.cur].dar, st.ch[st.cur].mode[7:6], usz,
                   st.ch[st.cur].ofs, st.cur == '0);
        // extended repeat area: a power-of-two window sized by rpt units (rpt times unit size in bytes)
        ext_mask = (32'(st.ch[st.cur].rpt) * 32'(usz)) - 32'h1;
        if (st.ch[st.cur].mode[`MMD_MODE_EIE] &&
            ((nsa & ~ext_mask) != (st.ch[st.cur].sar0 & ~ext_mask))) begin
          next_st.ch[st.cur].ist[`MMD_IRQ_ESC] = 1'b1;
        end
        next_st.ch[st.cur].sar = nsa;
        next_st.ch[st.cur].dar = nda;
        last_unit = (st.ch[st.cur].rleft <= 11'h1);
        next_st.ch[st.cur].rleft = st.ch[st.cur].rleft - 11'h1;
        case (mmd_tmode_t'(st.ch[st.cur].mode[3:2]))
          MMD_TM_NORMAL: begin
            next_st.ch[st.cur].pend = 1'b0;
            next_st.ch[st.cur].cnt  = st.ch[st.cur].cnt - 32'h1;
            cnt_done = (st.ch[st.cur].cnt <= 32'h1);
          end
          MMD_TM_REPEAT: begin
            next_st.ch[st.cur].pend = 1'b0;
            if (last_unit) begin
              next_st.ch[st.cur].rleft = st.ch[st.cur].rpt;
              next_st.ch[st.cur].sar   = st.ch[st.cur].sar0;
              next_st.ch[st.cur].ist[`MMD_IRQ_ESC] = 1'b1;
              next_st.ch[st.cur].cnt = st.ch[st.cur].cnt - 32'h1;
              cnt_done = (st.ch[st.cur].cnt <= 32'h1);
            end
          end
          default: begin
            // a block runs to its end on one request
            if (last_unit) begin
              next_st.ch[st.cur].pend  = 1'b0;
              next_st.ch[st.cur].rleft = st.ch[st.cur].rpt;
              next_st.ch[st.cur].ist[`MMD_IRQ_ESC] = 1'b1;
              next_st.ch[st.cur].cnt = st.ch[st.cur].cnt - 32'h1;
              cnt_done = (st.ch[st.cur].cnt[16:0] <= 17'h1);
            end
          end
        endcase
        if (cnt_done) begin
          next_st.ch[st.cur].en = 1'b0;
          next_st.ch[st.cur].ist[`MMD_IRQ_END] = 1'b1;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register and peripheral request synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st      <= '0;
      preq_s1 <= '0;
      preq_s2 <= '0;
    end else begin
      st      <= next_st;
      preq_s1 <= periph_req;
      preq_s2 <= preq_s1;
    end
  end

  // outputs
  always_comb begin
    irq = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      irq = irq | (|(st.ch[i].ist & st.ch[i].imsk));
    end
  end

  assign reg_rdata = st.rdata;
  assign bus_addr  = st.baddr;
  assign bus_wdata = st.bwdata;
  assign bus_be    = st.bbe;
  assign bus_rd    = st.brd;
  assign bus_wr    = st.bwr;
endmodule
`default_nettype wire

// >>> testbench/mmd_mem_model.sv
// mmd_mem_model: behavioural memory standing on the engine's bus side
// assumes: read data stand in the bus_rd cycle itself; writes are always taken
`timescale 1ns/100ps
`default_nettype none
module mmd_mem_model #(
  parameter logic [31:0] PAT = 32'h5A5A_5A5A
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        bus_rd,
  input  wire logic [31:0] bus_addr,
  output logic      [31:0] bus_rdata
);
  // data are a pure function of the address, answered in the bus_rd cycle;
  // otherwise the lines show the inverse of the last answer, never valid data
  logic [31:0] last;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      last <= 32'h0000_0000;
    end else if (bus_rd) begin
      last <= bus_addr ^ PAT;
    end
  end
  assign bus_rdata = bus_rd ? (bus_addr ^ PAT) : ~last;
endmodule
`default_nettype wire

// >>> testbench/mmd_dma_props.sv
// mmd_dma_props: timing, address-window and byte-lane checks on the transfer engine's top-level ports
// assumes: bound into mmd_dma; single clock mclk, async reset rst
`timescale 1ns/100ps
`default_nettype none
`include "mmd_consts.svh"
module mmd_dma_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic [31:0] bus_addr,
  input wire logic [3:0]  bus_be,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // bus access shape
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  addr_window_a: assert property (
    (bus_rd || bus_wr) |-> (bus_addr <= `MMD_LOW_TOP || bus_addr >= `MMD_HIGH_BASE))
    else $error("bus address outside both windows");
  read_then_write_a: assert property (
    bus_rd |=> bus_wr) else $error("read not followed by write");
  write_needs_read_a: assert property (
    bus_wr |-> $past(bus_rd)) else $error("write without preceding read");
  same_width_a: assert property (
    bus_wr |-> $countones(bus_be) == $countones($past(bus_be)))
    else $error("write width differs from read width");
  lane_legal_a: assert property (
    (bus_rd || bus_wr) |-> bus_be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
    else $error("byte enables are not a legal unit");
  lane_align_a: assert property (
    ((bus_rd || bus_wr) && bus_be == 4'hF) |-> bus_addr[1:0] == 2'b00)
    else $error("word access not aligned");
  unit_spacing_a: assert property (
    bus_rd |=> !bus_rd ##1 !bus_rd) else $error("units overlap on the bus");
  // the interrupt may only rise after a unit lands or software writes a register
  irq_cause_a: assert property (
    $rose(irq) |-> ($past(bus_wr, 1) || $past(bus_wr, 2) || $past(bus_wr, 3)
                    || $past(reg_wr, 1) || $past(reg_wr, 2)))
    else $error("interrupt rose without cause");
endmodule
bind mmd_dma mmd_dma_props u_props (
  .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .bus_addr(bus_addr),
  .bus_be(bus_be), .bus_rd(bus_rd), .bus_wr(bus_wr), .irq(irq)
);
`default_nettype wire

// >>> testbench/multi_mode_dma_transfer_tb.sv
// multi_mode_dma_transfer_tb: register-driven scenarios for the transfer engine
// assumes: mmd_dma with a behavioural memory; unmask only channel 0's end bit
`timescale 1ns/100ps
`default_nettype none
`include "mmd_consts.svh"
module multi_mode_dma_transfer_tb;
  import mmd_pkg::*;
  localparam logic [31:0] PAT = 32'h5A5A_5A5A;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] periph_req = 16'h0000;
  logic [15:0] ext_pin = 16'hFFFF;
  logic [31:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [3:0]  bus_be;
  logic        bus_rd;
  logic        bus_wr;
  logic [31:0] bus_rdata;
  logic        irq;
  logic [31:0] rq[$];
  logic [31:0] wq_a[$];
  logic [31:0] wq_d[$];
  logic [3:0]  wq_b[$];
  int          n_fail = 0;
  int          num_checks = 0;

  mmd_dma DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
    .ext_pin(ext_pin), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_rdata(bus_rdata), .irq(irq));
  mmd_mem_model #(.PAT(PAT)) u_mem (.mclk(mclk), .rst(rst), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_rdata(bus_rdata));

  initial begin
    forever #2 mclk = ~mclk;
  end

  // record every bus access so units can be compared in order
  always @(posedge mclk) begin
    if (bus_rd) rq.push_back(bus_addr);
    if (bus_wr) begin
      wq_a.push_back(bus_addr);
      wq_d.push_back(bus_wdata);
      wq_b.push_back(bus_be);
    end
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] exp, string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask
  // bounded wait: a missing write is a mismatch and ends the run
  task automatic wait_wr(int n);
    for (int k = 0; k < 400 && wq_a.size() < n; k++) begin
      @(posedge mclk);
      #1;
    end
    if (wq_a.size() < n) begin
      n_fail++;
      $display("wrong value write count expected %0d seen %0d", n, wq_a.size());
      wrap_up();
    end
  endtask
  function automatic logic [3:0] be_of(mmd_size_t s, logic [31:0] a);
    case (s)
      MMD_SZ_8:  return 4'h1 << a[1:0];
      MMD_SZ_16: return a[1] ? 4'hC : 4'h3;
      default:   return 4'hF;
    endcase
  endfunction
  function automatic logic [31:0] md(mmd_size_t s, mmd_tmode_t t, mmd_amode_t sm,
                                     mmd_amode_t dm, logic [3:0] sel, logic ext, logic [1:0] ie);
    return {14'h0000, ie, 3'h0, ext, sel, dm, sm, t, s};
  endfunction
  task automatic unit(mmd_size_t s, logic [31:0] sa, logic [31:0] da);
    logic [31:0] d;
    wait_wr(1);
    check("read address", rq.pop_front(), sa);
    check("write address", wq_a.pop_front(), da);
    check("byte enables", 32'(wq_b.pop_front()), 32'(be_of(s, da)));
    d = wq_d.pop_front();
    if (s == MMD_SZ_32) check("write data", d, sa ^ PAT);
  endtask
  task automatic prog(logic [3:0] ch, logic [31:0] sa, logic [31:0] da, logic [31:0] cnt,
                      logic [31:0] rpt, logic [31:0] mode);
    wr({ch, 4'h0} + `MMD_REG_SAR, sa);
    wr({ch, 4'h0} + `MMD_REG_DAR, da);
    wr({ch, 4'h0} + `MMD_REG_CNT, cnt);
    wr({ch, 4'h0} + `MMD_REG_RPT, rpt);
    wr({ch, 4'h0} + `MMD_REG_MODE, mode);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int i;
    int j;
    mmd_edge_t em[4];
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rdchk(8'h0B, 32'h0000_0000, "unmapped word");
    rdchk(8'h09, 32'h0000_0000, "status after reset");
    // normal mode, source up and destination down, end raises the interrupt
    prog(0, 32'h0000_1000, 32'h0000_2008, 2, 0,
         md(MMD_SZ_32, MMD_TM_NORMAL, MMD_AM_INC, MMD_AM_DEC, 0, 0, 0));
    wr(8'h08, 32'h0000_0001);
    for (i = 0; i < 2; i++) begin
      check("irq early", 32'(irq), 0);
      wr(8'h06, 32'h0000_0003);
      unit(MMD_SZ_32, 32'h0000_1000 + 4 * i, 32'h0000_2008 - 4 * i);
    end
    rdchk(8'h09, 32'h0000_0001, "normal end status");
    check("irq raised", 32'(irq), 1);
    wr(8'h09, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    #1;
    check("irq cleared", 32'(irq), 0);
    // offset step works on channel 0 only; channel 1 holds the address
    for (i = 0; i < 2; i++) begin
      wr({4'(i), 4'h5}, 32'h0000_0010);
      prog(4'(i), 32'h0000_0100, 32'h0000_0200, 2, 0,
           md(MMD_SZ_8, MMD_TM_NORMAL, MMD_AM_OFFSET, MMD_AM_INC, 0, 0, 0));
      for (j = 0; j < 2; j++) begin
        wr({4'(i), 4'h6}, 32'h0000_0003);
        unit(MMD_SZ_8, 32'h0000_0100 + (i == 0 ? 16 * j : 0), 32'h0000_0200 + j);
      end
    end
    wr(8'h09, 32'h0000_0003);
    // repeat mode: one repetition of two units gives end and escape together
    wr(8'h19, 32'h0000_0003);
    prog(1, 32'h0000_0302, 32'h0000_0400, 1, 2,
         md(MMD_SZ_16, MMD_TM_REPEAT, MMD_AM_INC, MMD_AM_FIXED, 0, 0, 2'b01));
    wr(8'h16, 32'h0000_0003);
    unit(MMD_SZ_16, 32'h0000_0302, 32'h0000_0400);
    rdchk(8'h19, 32'h0000_0000, "repeat status mid");
    wr(8'h16, 32'h0000_0003);
    unit(MMD_SZ_16, 32'h0000_0304, 32'h0000_0400);
    rdchk(8'h19, 32'h0000_0003, "repeat status end");
    // leaving a two-byte extended area sets escape before any end
    prog(0, 32'h0000_0501, 32'h0000_0600, 4, 2,
         md(MMD_SZ_8, MMD_TM_NORMAL, MMD_AM_INC, MMD_AM_FIXED, 0, 0, 2'b10));
    wr(8'h06, 32'h0000_0003);
    unit(MMD_SZ_8, 32'h0000_0501, 32'h0000_0600);
    rdchk(8'h09, 32'h0000_0002, "overflow escape");
    wr(8'h06, 32'h0000_0000);
    wr(8'h09, 32'h0000_0003);
    // block mode: two blocks of four units, one request each, end is masked
    prog(2, 32'h0000_0600, 32'h0000_0700, 2, 4,
         md(MMD_SZ_32, MMD_TM_BLOCK, MMD_AM_INC, MMD_AM_INC, 0, 0, 0));
    for (i = 0; i < 8; i++) begin
      if (i == 4) rdchk(8'h29, 32'h0000_0002, "block status mid");
      if (i % 4 == 0) wr(8'h26, 32'h0000_0003);
      unit(MMD_SZ_32, 32'h0000_0600 + 4 * i, 32'h0000_0700 + 4 * i);
    end
    rdchk(8'h29, 32'h0000_0003, "block end status");
    check("irq masked", 32'(irq), 0);
    wr(8'h23, 32'h0000_07FF);
    rdchk(8'h23, 32'h0000_0400, "block size limit");
    // addresses that run off the low window continue in the high one
    prog(3, 32'h0FFF_FFFC, 32'hF000_0000, 2, 0,
         md(MMD_SZ_32, MMD_TM_NORMAL, MMD_AM_INC, MMD_AM_DEC, 0, 0, 0));
    wr(8'h36, 32'h0000_0003);
    unit(MMD_SZ_32, 32'h0FFF_FFFC, 32'hF000_0000);
    wr(8'h36, 32'h0000_0003);
    unit(MMD_SZ_32, 32'hF000_0000, 32'h0FFF_FFFC);
    // pin trigger in each detection mode; idle level set before the mode,
    // so the level change itself never counts as an event
    em = '{MMD_EX_FALL, MMD_EX_RISE, MMD_EX_BOTH, MMD_EX_LOW};
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      ext_pin[3] <= (em[i] == MMD_EX_FALL || em[i] == MMD_EX_LOW);
      prog(2, 32'h0000_0800, 32'h0000_0900, 1, 0,
           md(MMD_SZ_8, MMD_TM_NORMAL, MMD_AM_FIXED, MMD_AM_FIXED, 3, 1, 0));
      wr(8'h4A, 32'(em[i]) << 6);
      wr(8'h26, 32'h0000_0001);
      repeat (8) @(posedge mclk);
      check("early writes", 32'(wq_a.size()), 0);
      ext_pin[3] <= ~ext_pin[3];
      unit(MMD_SZ_8, 32'h0000_0800, 32'h0000_0900);
    end
    // one peripheral request for two channels: the lower index goes first
    prog(3, 32'h0000_3100, 32'h0000_3200, 1, 0,
         md(MMD_SZ_32, MMD_TM_NORMAL, MMD_AM_FIXED, MMD_AM_FIXED, 5, 0, 0));
    prog(1, 32'h0000_1100, 32'h0000_1200, 1, 0,
         md(MMD_SZ_32, MMD_TM_NORMAL, MMD_AM_FIXED, MMD_AM_FIXED, 5, 0, 0));
    wr(8'h36, 32'h0000_0001);
    wr(8'h16, 32'h0000_0001);
    periph_req[5] <= 1'b1;
    unit(MMD_SZ_32, 32'h0000_1100, 32'h0000_1200);
    unit(MMD_SZ_32, 32'h0000_3100, 32'h0000_3200);
    wrap_up();
  end
endmodule
`default_nettype wire
